//--- design/lspr_pkg.sv
// Constants for the segment phase register bank: address map, field layout,
// reset values and bus answer codes.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
package lspr_pkg;

    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Display pins held by this bank
    localparam int PIN_FIRST = 11;
    localparam int PIN_LAST  = 38;
    localparam int PIN_CNT   = PIN_LAST - PIN_FIRST + 1;
    localparam int PHASE_CNT = 8;

    // Phase bit positions inside a segment phase register
    localparam int PHASE_A_BIT = 0;
    localparam int PHASE_B_BIT = 1;
    localparam int PHASE_C_BIT = 2;
    localparam int PHASE_D_BIT = 3;
    localparam int PHASE_E_BIT = 4;
    localparam int PHASE_F_BIT = 5;
    localparam int PHASE_G_BIT = 6;
    localparam int PHASE_H_BIT = 7;

    // Byte offsets of the control registers
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] PEN_OFS    = 12'h004;
    localparam logic [ADDR_W-1:0] BPSEL_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h00C;

    // Segment phase register of pin n sits at WF_BASE + 4*n
    localparam logic [ADDR_W-1:0] WF_BASE       = 12'h100;
    localparam logic [9:0]        WF_WORD_FIRST = 10'h04B;
    localparam logic [9:0]        WF_WORD_LAST  = 10'h066;

    // Control register fields
    localparam int CTRL_DRV_EN_BIT = 0;

    // Status register fields
    localparam int STAT_DRV_EN_BIT = 0;
    localparam int STAT_PHASE_LSB  = 4;
    localparam int STAT_ACTIVE_LSB = 8;

    // Values after reset
    localparam logic                RST_DRV_EN = 1'b0;
    localparam logic [PIN_CNT-1:0]  RST_PEN    = 28'h0000000;
    localparam logic [PIN_CNT-1:0]  RST_BPSEL  = 28'h0000000;

    // Bus answer codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        LSPR_WR_COLLECT = 1'b0,
        LSPR_WR_RESP    = 1'b1
    } lspr_wr_state_t;

    typedef enum logic [0:0] {
        LSPR_RD_IDLE = 1'b0,
        LSPR_RD_RESP = 1'b1
    } lspr_rd_state_t;

endpackage : lspr_pkg

//--- design/lspr_top.sv
// Segment phase register bank of a segment display driver, pins 11 to 38,
// with its enable and backplane-select controls, behind an AXI4-Lite slave.
// Assumes phase_idx comes from the waveform generator on the same clock.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Each pin register holds one bit per backplane phase, A to H.
// - On a frontplane pin, the current phase bit switches its segment on or off.
// - On a backplane pin, set bits choose phases where the pin is active.
// - Segment phase registers have no reset value; contents undefined until written.
// - Contents survive entry to and exit from the deepest stop mode.
// - Backplane select 0 makes the pin frontplane, 1 makes it backplane.
// - A pin acts only with its pin enable and the driver enable set; here pin_backplane follows backplane select even with either enable clear.
module lspr_top (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Write address channel
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [lspr_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic [2:0]                    awprot,
    // Write data channel
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [lspr_pkg::DATA_W-1:0]   wdata,
    input  wire logic [lspr_pkg::STRB_W-1:0]   wstrb,
    // Write response channel
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    // Read address channel
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [lspr_pkg::ADDR_W-1:0]   araddr,
    input  wire logic [2:0]                    arprot,
    // Read data channel
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [lspr_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                         rresp,
    // Phase from the waveform generator
    input  wire logic [2:0]                    phase_idx,
    // Per-pin display outputs
    output logic [lspr_pkg::PIN_CNT-1:0]       pin_active,
    output logic [lspr_pkg::PIN_CNT-1:0]       pin_backplane,
    output logic [lspr_pkg::PIN_CNT-1:0]       pin_lcd_mode
);

    // Word decode of the segment phase window
    function automatic logic wf_hit(input logic [lspr_pkg::ADDR_W-1:0] a);
        wf_hit = (a[11:2] >= lspr_pkg::WF_WORD_FIRST) && (a[11:2] <= lspr_pkg::WF_WORD_LAST);
    endfunction : wf_hit

    function automatic logic [4:0] wf_slot(input logic [lspr_pkg::ADDR_W-1:0] a);
        logic [9:0] diff;
        diff = a[11:2] - lspr_pkg::WF_WORD_FIRST;
        wf_slot = diff[4:0];
    endfunction : wf_slot

    // Byte-lane merge for the wide control registers
    function automatic logic [lspr_pkg::PIN_CNT-1:0] lane_merge(
        input logic [lspr_pkg::PIN_CNT-1:0] old_v,
        input logic [lspr_pkg::DATA_W-1:0]  new_v,
        input logic [lspr_pkg::STRB_W-1:0]  strb
    );
        logic [lspr_pkg::DATA_W-1:0] tmp;
        tmp = {4'h0, old_v};
        for (int b = 0; b < lspr_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                tmp[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        lane_merge = tmp[lspr_pkg::PIN_CNT-1:0];
    endfunction : lane_merge

    // Write channel state
    lspr_pkg::lspr_wr_state_t       wr_state_q;
    lspr_pkg::lspr_wr_state_t       wr_state_d;
    logic                           aw_have_q;
    logic                           aw_have_d;
    logic                           w_have_q;
    logic                           w_have_d;
    logic [lspr_pkg::ADDR_W-1:0]    wr_addr_q;
    logic [lspr_pkg::ADDR_W-1:0]    wr_addr_d;
    logic [lspr_pkg::DATA_W-1:0]    wr_data_q;
    logic [lspr_pkg::DATA_W-1:0]    wr_data_d;
    logic [lspr_pkg::STRB_W-1:0]    wr_strb_q;
    logic [lspr_pkg::STRB_W-1:0]    wr_strb_d;
    logic                           awready_q;
    logic                           awready_d;
    logic                           wready_q;
    logic                           wready_d;
    logic                           bvalid_q;
    logic                           bvalid_d;
    logic [1:0]                     bresp_q;
    logic [1:0]                     bresp_d;
    logic                           commit;
    logic [lspr_pkg::ADDR_W-1:0]    commit_addr;
    logic [lspr_pkg::DATA_W-1:0]    commit_data;
    logic [lspr_pkg::STRB_W-1:0]    commit_strb;

    // Read channel state
    lspr_pkg::lspr_rd_state_t       rd_state_q;
    lspr_pkg::lspr_rd_state_t       rd_state_d;
    logic                           arready_q;
    logic                           arready_d;
    logic                           rvalid_q;
    logic                           rvalid_d;
    logic [lspr_pkg::DATA_W-1:0]    rdata_q;
    logic [lspr_pkg::DATA_W-1:0]    rdata_d;
    logic [1:0]                     rresp_q;
    logic [1:0]                     rresp_d;
    logic [lspr_pkg::DATA_W-1:0]    rd_word;

    // Configuration and storage
    // one bit per phase
    logic                           drv_en_q;
    logic                           drv_en_d;
    logic [lspr_pkg::PIN_CNT-1:0]   pen_q;
    logic [lspr_pkg::PIN_CNT-1:0]   pen_d;
    logic [lspr_pkg::PIN_CNT-1:0]   bpsel_q;
    logic [lspr_pkg::PIN_CNT-1:0]   bpsel_d;
    logic [lspr_pkg::PHASE_CNT-1:0] wf_q [lspr_pkg::PIN_CNT];
    logic [lspr_pkg::PHASE_CNT-1:0] wf_d [lspr_pkg::PIN_CNT];
    logic [2:0]                     phase_q;

    // Display outputs
    logic [lspr_pkg::PIN_CNT-1:0]   pin_active_q;
    wire logic [lspr_pkg::PIN_CNT-1:0] pin_active_d;
    logic [lspr_pkg::PIN_CNT-1:0]   pin_backplane_q;
    wire logic [lspr_pkg::PIN_CNT-1:0] pin_backplane_d;
    logic [lspr_pkg::PIN_CNT-1:0]   pin_lcd_mode_q;
    wire logic [lspr_pkg::PIN_CNT-1:0] pin_lcd_mode_d;

    // Word match against a control register offset
    function automatic logic is_word(
        input logic [lspr_pkg::ADDR_W-1:0] a,
        input logic [lspr_pkg::ADDR_W-1:0] ofs
    );
        is_word = (a[11:2] == ofs[11:2]);
    endfunction : is_word

    function automatic logic reg_mapped(input logic [lspr_pkg::ADDR_W-1:0] a);
        if (is_word(a, lspr_pkg::CTRL_OFS)) begin
            reg_mapped = 1'b1;
        end else if (is_word(a, lspr_pkg::PEN_OFS)) begin
            reg_mapped = 1'b1;
        end else if (is_word(a, lspr_pkg::BPSEL_OFS)) begin
            reg_mapped = 1'b1;
        end else if (is_word(a, lspr_pkg::STATUS_OFS)) begin
            reg_mapped = 1'b1;
        end else if (wf_hit(a)) begin
            reg_mapped = 1'b1;
        end else begin
            reg_mapped = 1'b0;
        end
    endfunction : reg_mapped

    function automatic logic phase_pick(
        input logic [lspr_pkg::PHASE_CNT-1:0] bits,
        input logic [2:0]                     idx
    );
        phase_pick = bits[idx];
    endfunction : phase_pick

    // Write path; address and data may arrive in either order
    always_comb begin
        wr_state_d  = wr_state_q;
        aw_have_d   = aw_have_q;
        w_have_d    = w_have_q;
        wr_addr_d   = wr_addr_q;
        wr_data_d   = wr_data_q;
        wr_strb_d   = wr_strb_q;
        bvalid_d    = bvalid_q;
        bresp_d     = bresp_q;
        commit      = 1'b0;
        commit_addr = aw_have_q ? wr_addr_q : awaddr;
        commit_data = w_have_q ? wr_data_q : wdata;
        commit_strb = w_have_q ? wr_strb_q : wstrb;
        case (wr_state_q)
            lspr_pkg::LSPR_WR_COLLECT: begin
                if (awvalid && awready_q) begin
                    aw_have_d = 1'b1;
                    wr_addr_d = awaddr;
                end
                if (wvalid && wready_q) begin
                    w_have_d  = 1'b1;
                    wr_data_d = wdata;
                    wr_strb_d = wstrb;
                end
                // Commit at the edge that takes the last half
                if (aw_have_d && w_have_d) begin
                    commit     = 1'b1;
                    aw_have_d  = 1'b0;
                    w_have_d   = 1'b0;
                    bvalid_d   = 1'b1;
                    bresp_d    = reg_mapped(commit_addr) ? lspr_pkg::RESP_OKAY : lspr_pkg::RESP_SLVERR;
                    wr_state_d = lspr_pkg::LSPR_WR_RESP;
                end
            end
            lspr_pkg::LSPR_WR_RESP: begin
                if (bready) begin
                    bvalid_d   = 1'b0;
                    wr_state_d = lspr_pkg::LSPR_WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = lspr_pkg::LSPR_WR_COLLECT;
            end
        endcase
        // Ready only while that half is still wanted
        awready_d = (wr_state_d == lspr_pkg::LSPR_WR_COLLECT) && !aw_have_d;
        wready_d  = (wr_state_d == lspr_pkg::LSPR_WR_COLLECT) && !w_have_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= lspr_pkg::LSPR_WR_COLLECT;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            wr_addr_q  <= 12'h000;
            wr_data_q  <= 32'h00000000;
            wr_strb_q  <= 4'h0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= lspr_pkg::RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            wr_addr_q  <= wr_addr_d;
            wr_data_q  <= wr_data_d;
            wr_strb_q  <= wr_strb_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
        end
    end

    // Read path; data is captured when the address is taken
    always_comb begin
        rd_state_d = rd_state_q;
        rvalid_d   = rvalid_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        case (rd_state_q)
            lspr_pkg::LSPR_RD_IDLE: begin
                if (arvalid && arready_q) begin
                    rvalid_d   = 1'b1;
                    rdata_d    = rd_word;
                    rresp_d    = reg_mapped(araddr) ? lspr_pkg::RESP_OKAY : lspr_pkg::RESP_SLVERR;
                    rd_state_d = lspr_pkg::LSPR_RD_RESP;
                end
            end
            lspr_pkg::LSPR_RD_RESP: begin
                if (rready) begin
                    rvalid_d   = 1'b0;
                    rd_state_d = lspr_pkg::LSPR_RD_IDLE;
                end
            end
            default: begin
                rd_state_d = lspr_pkg::LSPR_RD_IDLE;
            end
        endcase
        arready_d = (rd_state_d == lspr_pkg::LSPR_RD_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= lspr_pkg::LSPR_RD_IDLE;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h00000000;
            rresp_q    <= lspr_pkg::RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

    // Read word mux; unused bits read as zero
    always_comb begin
        rd_word = 32'h00000000;
        if (is_word(araddr, lspr_pkg::CTRL_OFS)) begin
            rd_word[lspr_pkg::CTRL_DRV_EN_BIT] = drv_en_q;
        end else if (is_word(araddr, lspr_pkg::PEN_OFS)) begin
            rd_word = {4'h0, pen_q};
        end else if (is_word(araddr, lspr_pkg::BPSEL_OFS)) begin
            rd_word = {4'h0, bpsel_q};
        end else if (is_word(araddr, lspr_pkg::STATUS_OFS)) begin
            rd_word[lspr_pkg::STAT_DRV_EN_BIT]       = drv_en_q;
            rd_word[lspr_pkg::STAT_PHASE_LSB +: 3]   = phase_q;
            rd_word[lspr_pkg::STAT_ACTIVE_LSB]       = |pin_active_q;
        end else if (wf_hit(araddr)) begin
            rd_word[7:0] = wf_q[wf_slot(araddr)];
        end
    end

    // Control registers take any byte lanes
    always_comb begin
        drv_en_d = drv_en_q;
        pen_d    = pen_q;
        bpsel_d  = bpsel_q;
        if (commit && commit_strb[0] && is_word(commit_addr, lspr_pkg::CTRL_OFS)) begin
            drv_en_d = commit_data[lspr_pkg::CTRL_DRV_EN_BIT];
        end
        if (commit && is_word(commit_addr, lspr_pkg::PEN_OFS)) begin
            pen_d = lane_merge(pen_q, commit_data, commit_strb);
        end
        if (commit && is_word(commit_addr, lspr_pkg::BPSEL_OFS)) begin
            bpsel_d = lane_merge(bpsel_q, commit_data, commit_strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_en_q <= lspr_pkg::RST_DRV_EN;
            pen_q    <= lspr_pkg::RST_PEN;
            bpsel_q  <= lspr_pkg::RST_BPSEL;
        end else begin
            drv_en_q <= drv_en_d;
            pen_q    <= pen_d;
            bpsel_q  <= bpsel_d;
        end
    end

    // Only lane 0 lands; wider writes leave the other lanes unused
    always_comb begin
        wf_d = wf_q;
        if (commit && commit_strb[0] && wf_hit(commit_addr)) begin
            wf_d[wf_slot(commit_addr)] = commit_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        wf_q <= wf_d;
    end

    for (genvar k = 0; k < lspr_pkg::PIN_CNT; k++) begin : g_pin
        assign pin_active_d[k] = pin_lcd_mode_d[k] & phase_pick(wf_q[k], phase_idx);
    end
    assign pin_lcd_mode_d = {lspr_pkg::PIN_CNT{drv_en_q}} & pen_q;
    assign pin_backplane_d = bpsel_q;

    // Pin outputs registered so they never glitch on a bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_active_q    <= 28'h0000000;
            pin_backplane_q <= 28'h0000000;
            pin_lcd_mode_q  <= 28'h0000000;
            phase_q         <= 3'h0;
        end else begin
            pin_active_q    <= pin_active_d;
            pin_backplane_q <= pin_backplane_d;
            pin_lcd_mode_q  <= pin_lcd_mode_d;
            phase_q         <= phase_idx;
        end
    end

    // Ports straight from flip-flops
    assign awready       = awready_q;
    assign wready        = wready_q;
    assign bvalid        = bvalid_q;
    assign bresp         = bresp_q;
    assign arready       = arready_q;
    assign rvalid        = rvalid_q;
    assign rdata         = rdata_q;
    assign rresp         = rresp_q;
    assign pin_active    = pin_active_q;
    assign pin_backplane = pin_backplane_q;
    assign pin_lcd_mode  = pin_lcd_mode_q;

endmodule : lspr_top
`default_nettype wire

//--- testbench/lspr_monitor.sv
// Port checker for the segment phase bank.
// Bound to lspr_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lspr_monitor (
    input wire logic        aclk, aresetn, awvalid, wvalid, wready, bvalid, bready, rvalid, rready,
    input wire logic [1:0]  bresp,
    input wire logic [31:0] rdata,
    input wire logic [2:0]  phase_idx,
    input wire logic [27:0] pin_active, pin_backplane, pin_lcd_mode
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet while no write half is offered; a commit needs one offered
    wire logic q = !(awvalid || wvalid);
    a_off_idle: assert property ((pin_active & ~pin_lcd_mode) == 0) else $error("off pin on");
    a_phase_kept: assert property ((q && $stable(phase_idx)) [*3] |-> $stable(pin_active)) else $error("lost");
    a_bp_kept: assert property (q [*3] |-> $stable(pin_backplane)) else $error("bp moved");
    a_mode_kept: assert property (q [*3] |-> $stable(pin_lcd_mode)) else $error("mode moved");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b drop");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r drop");
    a_resp_code: assert property (bvalid |-> !bresp[0]) else $error("bad bresp");
    a_rst_quiet: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid) else $error("busy");
    c_wr: cover property (bvalid && bready);
    c_rd: cover property (rvalid && rready);
    c_on: cover property (|pin_active);
endmodule : lspr_monitor
bind lspr_top lspr_monitor lspr_monitor_i (.*);
`default_nettype wire

//--- testbench/lspr_top_tb.sv
// Bench: byte writes, read-back and phase outputs against a model.
// Assumes outputs settle within three clocks.
`timescale 1ns/1ps
`default_nettype none
module lspr_top_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic [2:0] awprot = 0, arprot = 0, phase_idx = 0;
    logic [1:0] bresp, rresp, r;
    logic [27:0] pin_active, pin_backplane, pin_lcd_mode, e, pin_enable_bit, bp;
    logic [7:0] m [28];
    int fail_count = 0, n_tests = 0, n;
    lspr_top lspr_top_i (.*);
    initial forever #50 aclk = ~aclk;
    task complete_run;
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task chk(string s, logic [31:0] x, logic [31:0] g);
        n_tests++;
        if (g !== x) begin fail_count++; $display("mismatch %s exp %h got %h", s, x, g); end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [31:0] d);
        bit ka = 0, kw = 0;
        @(posedge aclk); n = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        wstrb <= (a >= lspr_pkg::WF_BASE) ? 4'h1 : 4'hF;
        do begin @(posedge aclk); n++;
            if (awready && !ka) begin ka = 1; awvalid <= 0; end
            if (wready && !kw) begin kw = 1; wvalid <= 0; end
        end while (!bvalid && n < 99);
        r = bresp; bready <= 0;
        if (n >= 99) begin fail_count++; complete_run(); end
    endtask : wr
    task automatic rd(logic [11:0] a);
        @(posedge aclk); n = 0;
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(posedge aclk); n++; if (arready) arvalid <= 0; end while (!rvalid && n < 99);
        r = rresp; rready <= 0;
        if (n >= 99) begin fail_count++; complete_run(); end
    endtask : rd
    initial begin
        void'($urandom(81));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        for (int k = 0; k < 28; k++) begin
            m[k] = 8'($urandom);
            wr(lspr_pkg::WF_BASE + 12'(4 * (k + 11)), {24'h0, m[k]});
            chk("wresp", 32'h0, 32'(r));
        end
        for (int k = 0; k < 28; k++) begin
            rd(lspr_pkg::WF_BASE + 12'(4 * (k + 11)));
            chk("wf", {24'h0, m[k]}, rdata);
        end
        pin_enable_bit = 28'($urandom);
        bp = 28'($urandom);
        wr(lspr_pkg::PEN_OFS, 32'(pin_enable_bit));
        wr(lspr_pkg::BPSEL_OFS, 32'(bp));
        wr(lspr_pkg::CTRL_OFS, 32'h1);
        for (int p = 0; p < 8; p++) begin
            phase_idx <= 3'(p);
            repeat (3) @(posedge aclk);
            for (int k = 0; k < 28; k++) e[k] = pin_enable_bit[k] & m[k][p];
            chk("active", 32'(e), 32'(pin_active));
            chk("bp_active", 32'(e & bp), 32'(pin_active & pin_backplane));
        end
        chk("bp", 32'(bp), 32'(pin_backplane));
        chk("mode", 32'(pin_enable_bit), 32'(pin_lcd_mode));
        wr(lspr_pkg::CTRL_OFS, 32'h0);
        repeat (3) @(posedge aclk);
        chk("off", 32'h0, 32'(pin_active | pin_lcd_mode));
        rd(12'hFFC);
        chk("unmapped", 32'(lspr_pkg::RESP_SLVERR), 32'(r));
        complete_run();
    end
endmodule : lspr_top_tb
`default_nettype wire
